//--- design/ppp_defines.vh
// Constants for the parallel programming port
`ifndef PPP_DEFINES_VH
`define PPP_DEFINES_VH
`define PPP_ACT_ADDR     2'b00
`define PPP_ACT_DATA     2'b01
`define PPP_ACT_CMD      2'b10
`define PPP_BS_LO        2'b00
`define PPP_BS_HI        2'b01
`define PPP_BS_EXT       2'b10
`define PPP_BS_RSV       2'b11
`define PPP_CMD_NOP      8'h00
`define PPP_CMD_ERASE    8'h80
`define PPP_CMD_WFUSE    8'h40
`define PPP_CMD_WLOCK    8'h20
`define PPP_CMD_WFLASH   8'h10
`define PPP_CMD_WEEP     8'h11
`define PPP_CMD_RSIG     8'h08
`define PPP_CMD_RFUSE    8'h04
`define PPP_CMD_RFLASH   8'h02
`define PPP_CMD_REEP     8'h03
`define PPP_ERASED_BYTE  8'hff
`define PPP_FUSE_LO_RST  8'h62
`define PPP_FUSE_HI_RST  8'h99
`define PPP_FUSE_EX_RST  8'hff
`define PPP_LOCK_RST     8'hff
`define PPP_KEEP_EEP_BIT 3
`define PPP_ENTRY_EDGES  3'd6
`define PPP_ENTRY_NS     100
`define PPP_CLK_NS       20
`define PPP_PROG_US      4
`define PPP_ERASE_US     8
`endif

//--- design/ppp_port.v
// Parallel programming port of the device, with small internal memories
//
// Contract
// - Ready/busy low during program or erase, high when ready.
// - Data bus driven by device only while output enable is low.
// - Load strobe rising edge: 00 address, 01 data, 10 command, 11 idle.
// - Address byte select: 00 low, 01 high, 10 extended, 11 reserved.
// - Fuse/lock read and fuse write byte-select mapping as tabulated.
// - Low byte-select bit picks low or high half of flash data.
// - Entry-select change within 100 ns of high voltage aborts entry.
// - Command and address bytes persist across operations.
// - Ten command bytes decoded as tabulated.
// - Chip erase clears flash, EEPROM, locks; locks after flash; fuses kept.
// - Keep-EEPROM fuse programmed leaves EEPROM intact on erase.
// - Write strobe after erase command starts erase, ready/busy low.
// - Page latch with low byte-select high stores data word in buffer.
// - Low address bits pick buffer word, higher bits pick the page.
// - Write strobe with selects 00 writes the buffered flash page.
// - No-operation command ends page programming, clears write control.
// - EEPROM page load and write sequence as for flash.
// - Flash read: byte select low gives low byte, high gives high.
// - Fuses captured on entry; keep-EEPROM fuse acts immediately.
// - Lock bits return to unprogrammed only by chip erase; the code also reloads them to unprogrammed on RSTN_I reset.
`timescale 1ns/1ns
`include "ppp_defines.vh"
module ppp_port #(
  parameter PAGE_BITS  = 6,
  parameter FADDR_BITS = 10,
  parameter EPAGE_BITS = 2,
  parameter EADDR_BITS = 8,
  parameter [7:0] SIG0 = 8'h5a, // Arbitrary identity value
  parameter [7:0] SIG1 = 8'h01, // Arbitrary identity value
  parameter [7:0] SIG2 = 8'h02, // Arbitrary identity value
  parameter [7:0] CALIB = 8'h80,
  parameter PROG_CYC  = `PPP_PROG_US * 1000 / `PPP_CLK_NS,
  parameter ERASE_CYC = `PPP_ERASE_US * 1000 / `PPP_CLK_NS
) (
  // Clock and reset
  input  wire       MCLK_I,
  input  wire       RSTN_I,
  // Entry: low reset pin and high-voltage detect
  input  wire       RESET_PIN_N_I,
  input  wire       HV_I,
  // Programming strobes and selects
  input  wire       LOAD_STROBE_CLOCK_I,
  input  wire       ACTION_SEL_BIT0_I,
  input  wire       ACTION_SEL_BIT1_I,
  input  wire       BYTE_SELECT_LO_BIT_I,
  input  wire       BYTE_SELECT_HI_BIT_I,
  input  wire       PAGE_LATCH_STROBE_I,
  input  wire       WR_N_I,
  input  wire       OE_N_I,
  // Data bus
  input  wire [7:0] DATA_I,
  output reg  [7:0] DATA_O,
  output reg        DATA_OE_O,
  // Status
  output reg        READY_BUSY_N_O,
  output reg        PROG_MODE_O
);
  localparam S_IDLE  = 3'b001;
  localparam S_PROG  = 3'b010;
  localparam S_ERASE = 3'b100;
  localparam EXTRA = 2;
  localparam NSYNC = 10;
  localparam ENTRY_CYC = (`PPP_ENTRY_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS;
  // Erase sweeps several words a clock so it ends inside the erase time
  localparam EW_BITS = 2;
  localparam [FADDR_BITS:0] ERASE_STEP = {{(FADDR_BITS-EW_BITS){1'b0}}, 1'b1, {EW_BITS{1'b0}}};
  integer k;

  // Two-flop synchronisers for every pin
  reg [NSYNC-1:0] s1_q;
  reg [NSYNC-1:0] s2_q;
  reg [NSYNC-1:0] s3_q;
  wire [NSYNC-1:0] pins = {RESET_PIN_N_I, HV_I, LOAD_STROBE_CLOCK_I, ACTION_SEL_BIT0_I,
                           ACTION_SEL_BIT1_I, BYTE_SELECT_LO_BIT_I, BYTE_SELECT_HI_BIT_I,
                           PAGE_LATCH_STROBE_I, WR_N_I, OE_N_I};
  reg [7:0] d1_q;
  reg [7:0] d2_q;
  always @(posedge MCLK_I) begin
    s1_q <= pins;
    s2_q <= s1_q;
    s3_q <= s2_q;
    d1_q <= DATA_I;
    d2_q <= d1_q;
  end
  wire rst_pin_n = s2_q[9];
  wire hv        = s2_q[8];
  wire xl_rise   = s2_q[7] & ~s3_q[7];
  wire [1:0] act = {s2_q[5], s2_q[6]};
  wire [1:0] bs  = {s2_q[3], s2_q[4]};
  wire pl_rise   = s2_q[2] & ~s3_q[2];
  wire wr_fall   = ~s2_q[1] & s3_q[1];
  wire oe_n      = s2_q[0];
  wire [3:0] entry_sel = {s2_q[2], s2_q[5], s2_q[6], s2_q[4]};

  // Memories
  reg [15:0] flash_q [0:(1<<FADDR_BITS)-1];
  reg [7:0]  eep_q   [0:(1<<EADDR_BITS)-1];
  reg [15:0] fbuf_q  [0:(1<<PAGE_BITS)-1];
  reg [7:0]  ebuf_q  [0:(1<<EPAGE_BITS)-1];

  reg [2:0]  st_q;
  reg [7:0]  cmd_q;
  reg [23:0] addr_q;
  reg [15:0] dat_q;
  reg [7:0]  fuse_lo_q, fuse_hi_q, fuse_ex_q, lock_q;
  reg [7:0]  act_fhi_q;
  reg [2:0]  toggles_q;
  reg [3:0]  chk_q;
  reg        hv_seen_q, entry_bad_q;
  reg [22:0] tmr_q;
  reg [FADDR_BITS:0] wcnt_q;
  reg        erase_eep_q, is_eep_q, wr_armed_q;

  wire [FADDR_BITS-PAGE_BITS-1:0] fpage = addr_q[FADDR_BITS-1:PAGE_BITS];
  wire [EADDR_BITS-EPAGE_BITS-1:0] epage = addr_q[EADDR_BITS-1:EPAGE_BITS];
  wire [FADDR_BITS-1:0] wcnt_a = wcnt_q[FADDR_BITS-1:0];

  // Byte read out for the current command and selects
  function [7:0] rd_byte;
    input [7:0] c;
    input [1:0] b;
    begin
      case (c)
        `PPP_CMD_RFLASH: rd_byte = b[0] ? flash_q[addr_q[FADDR_BITS-1:0]][15:8]
                                        : flash_q[addr_q[FADDR_BITS-1:0]][7:0];
        `PPP_CMD_REEP:   rd_byte = eep_q[addr_q[EADDR_BITS-1:0]];
        `PPP_CMD_RSIG:   rd_byte = b[0] ? CALIB :
                                   (addr_q[1:0] == 2'd0) ? SIG0 :
                                   (addr_q[1:0] == 2'd1) ? SIG1 : SIG2;
        `PPP_CMD_RFUSE:  rd_byte = (b == `PPP_BS_LO)  ? fuse_lo_q :
                                   (b == `PPP_BS_HI)  ? lock_q :
                                   (b == `PPP_BS_EXT) ? fuse_ex_q : fuse_hi_q;
        default:         rd_byte = `PPP_ERASED_BYTE;
      endcase
    end
  endfunction

  always @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      st_q <= S_IDLE;
      cmd_q <= `PPP_CMD_NOP;
      addr_q <= 24'h000000;
      dat_q <= 16'h0000;
      fuse_lo_q <= `PPP_FUSE_LO_RST;
      fuse_hi_q <= `PPP_FUSE_HI_RST;
      fuse_ex_q <= `PPP_FUSE_EX_RST;
      lock_q <= `PPP_LOCK_RST;
      act_fhi_q <= `PPP_FUSE_HI_RST;
      toggles_q <= 3'd0;
      chk_q <= 4'h0;
      hv_seen_q <= 1'b0;
      entry_bad_q <= 1'b0;
      tmr_q <= 23'h000000;
      wcnt_q <= {(FADDR_BITS+1){1'b0}};
      erase_eep_q <= 1'b0;
      is_eep_q <= 1'b0;
      wr_armed_q <= 1'b0;
      PROG_MODE_O <= 1'b0;
      READY_BUSY_N_O <= 1'b1;
      DATA_O <= 8'h00;
      DATA_OE_O <= 1'b0;
    end else if (!PROG_MODE_O) begin
      READY_BUSY_N_O <= 1'b1;
      DATA_OE_O <= 1'b0;
      if (!rst_pin_n && !hv) begin
        hv_seen_q <= 1'b0;
        entry_bad_q <= 1'b0;
        if (xl_rise && toggles_q != `PPP_ENTRY_EDGES)
          toggles_q <= toggles_q + 3'd1;
      end else if (hv && toggles_q == `PPP_ENTRY_EDGES) begin
        // entry selects must stay 0000 for 100 ns
        if (!hv_seen_q) begin
          hv_seen_q <= 1'b1;
          chk_q <= 4'h0;
          entry_bad_q <= (entry_sel != 4'h0);
        end else if (entry_sel != 4'h0) begin
          entry_bad_q <= 1'b1;
        end else if (chk_q != ENTRY_CYC[3:0]) begin
          chk_q <= chk_q + 4'h1;
        end else if (!entry_bad_q) begin
          PROG_MODE_O <= 1'b1;
          act_fhi_q <= fuse_hi_q;
        end
      end
    end else if (!hv) begin
      PROG_MODE_O <= 1'b0;
      toggles_q <= 3'd0;
      hv_seen_q <= 1'b0;
      act_fhi_q <= fuse_hi_q;
    end else begin
      // drive only while output enable low
      DATA_OE_O <= ~oe_n;
      DATA_O <= rd_byte(cmd_q, bs);
      case (st_q)
        S_IDLE: begin
          READY_BUSY_N_O <= 1'b1;
          // sample only on load strobe rise
          if (xl_rise) begin
            case (act)
              `PPP_ACT_ADDR: begin
                if (bs == `PPP_BS_LO) addr_q[7:0] <= d2_q;
                else if (bs == `PPP_BS_HI) addr_q[15:8] <= d2_q;
                else if (bs == `PPP_BS_EXT) addr_q[23:16] <= d2_q;
              end
              // data half chosen by low select
              `PPP_ACT_DATA: begin
                if (bs[0]) dat_q[15:8] <= d2_q;
                else dat_q[7:0] <= d2_q;
              end
              `PPP_ACT_CMD: begin
                cmd_q <= d2_q;
                if (d2_q == `PPP_CMD_NOP) wr_armed_q <= 1'b0;
                else wr_armed_q <= 1'b1;
              end
              default: ;
            endcase
          end
          if (pl_rise && bs[0] && wr_armed_q) begin
            // low address bits pick buffer word
            if (cmd_q == `PPP_CMD_WFLASH) fbuf_q[addr_q[PAGE_BITS-1:0]] <= dat_q;
            if (cmd_q == `PPP_CMD_WEEP) ebuf_q[addr_q[EPAGE_BITS-1:0]] <= dat_q[7:0];
          end
          if (wr_fall && wr_armed_q) begin
            tmr_q <= 23'h000000;
            wcnt_q <= {(FADDR_BITS+1){1'b0}};
            case (cmd_q)
              `PPP_CMD_ERASE: begin
                st_q <= S_ERASE;
                READY_BUSY_N_O <= 1'b0;
                erase_eep_q <= fuse_hi_q[`PPP_KEEP_EEP_BIT];
              end
              `PPP_CMD_WFLASH, `PPP_CMD_WEEP: begin
                if (bs == `PPP_BS_LO) begin
                  st_q <= S_PROG;
                  READY_BUSY_N_O <= 1'b0;
                  is_eep_q <= cmd_q[0];
                end
              end
              `PPP_CMD_WFUSE: begin
                st_q <= S_PROG;
                READY_BUSY_N_O <= 1'b0;
                is_eep_q <= 1'b0;
                if (bs == `PPP_BS_LO) fuse_lo_q <= dat_q[7:0];
                else if (bs == `PPP_BS_HI) fuse_hi_q <= dat_q[7:0];
                else if (bs == `PPP_BS_EXT) fuse_ex_q <= dat_q[7:0];
              end
              // lock bits can only be programmed
              `PPP_CMD_WLOCK: begin
                st_q <= S_PROG;
                READY_BUSY_N_O <= 1'b0;
                is_eep_q <= 1'b0;
                lock_q <= lock_q & dat_q[7:0];
              end
              default: ;
            endcase
          end
        end
        S_PROG: begin
          READY_BUSY_N_O <= 1'b0;
          if (wcnt_q < (1 << PAGE_BITS)) begin
            if (cmd_q == `PPP_CMD_WFLASH)
              flash_q[{fpage, wcnt_q[PAGE_BITS-1:0]}] <= fbuf_q[wcnt_q[PAGE_BITS-1:0]];
            if (is_eep_q && wcnt_q < (1 << EPAGE_BITS))
              eep_q[{epage, wcnt_q[EPAGE_BITS-1:0]}] <= ebuf_q[wcnt_q[EPAGE_BITS-1:0]];
            wcnt_q <= wcnt_q + 1'b1;
          end
          tmr_q <= tmr_q + 23'd1;
          if (tmr_q == PROG_CYC[22:0]) begin
            st_q <= S_IDLE;
            READY_BUSY_N_O <= 1'b1;
          end
        end
        S_ERASE: begin
          READY_BUSY_N_O <= 1'b0;
          // flash erased, EEPROM too when erase_eep_q is set, then locks
          if (wcnt_q < (1 << FADDR_BITS)) begin
            for (k = 0; k < (1 << EW_BITS); k = k + 1) begin
              flash_q[{wcnt_a[FADDR_BITS-1:EW_BITS], k[EW_BITS-1:0]}] <=
                {`PPP_ERASED_BYTE, `PPP_ERASED_BYTE};
              if (erase_eep_q && wcnt_q < (1 << EADDR_BITS))
                eep_q[{wcnt_a[EADDR_BITS-1:EW_BITS], k[EW_BITS-1:0]}] <= `PPP_ERASED_BYTE;
            end
            wcnt_q <= wcnt_q + ERASE_STEP;
          end else begin
            lock_q <= `PPP_LOCK_RST;
          end
          tmr_q <= tmr_q + 23'd1;
          // Busy also covers the sweep, should memories outgrow the erase time
          if (tmr_q >= ERASE_CYC[22:0] && wcnt_q[FADDR_BITS]) begin
            st_q <= S_IDLE;
            READY_BUSY_N_O <= 1'b1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // ppp_port

//--- test/ppp_port_props.sv
// Checker for the parallel programming port
`timescale 1ns/1ns
module ppp_port_props #(
  parameter PROG_CYC  = 200,
  parameter ERASE_CYC = 400
) (
  // Clock, reset and entry
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic HV_I,
  // Selects and strobes
  input wire logic ACTION_SEL_BIT0_I,
  input wire logic ACTION_SEL_BIT1_I,
  input wire logic BYTE_SELECT_LO_BIT_I,
  input wire logic PAGE_LATCH_STROBE_I,
  input wire logic WR_N_I,
  input wire logic OE_N_I,
  // Outputs
  input wire logic DATA_OE_O,
  input wire logic READY_BUSY_N_O,
  input wire logic PROG_MODE_O
);
  localparam int BMAX = ERASE_CYC + 20;
  logic [9:0] busy_q;
  logic [4:0] age_q;
  logic       wr_n_q;
  wire        quiet = !(ACTION_SEL_BIT0_I | ACTION_SEL_BIT1_I | BYTE_SELECT_LO_BIT_I
                        | PAGE_LATCH_STROBE_I);
  // Age saturates so an old write edge never explains a busy
  always @(posedge MCLK_I) begin
    wr_n_q <= WR_N_I;
    busy_q <= (READY_BUSY_N_O || !RSTN_I) ? 10'h0 : busy_q + 10'h1;
    if (!RSTN_I) age_q <= 5'h1f;
    else if (wr_n_q && !WR_N_I) age_q <= 5'h0;
    else if (age_q != 5'h1f) age_q <= age_q + 5'h1;
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_busy;
    $fell(READY_BUSY_N_O);
  endsequence
  sequence s_oe_low;
    (!OE_N_I && PROG_MODE_O) [*8];
  endsequence
  rst_idle_a:
    assert property ($rose(RSTN_I) |-> READY_BUSY_N_O && !PROG_MODE_O && !DATA_OE_O)
    else $error("outputs not idle after reset");
  oe_drive_a:
    assert property (s_oe_low |-> DATA_OE_O) else $error("bus not driven on read");
  oe_release_a:
    assert property (OE_N_I [*8] |-> !DATA_OE_O) else $error("bus driven without enable");
  busy_cause_a:
    assert property (s_busy |-> age_q <= 5'd8) else $error("busy without write strobe");
  busy_end_a:
    assert property (s_busy |-> ##[1:BMAX] READY_BUSY_N_O) else $error("busy never ends");
  busy_span_a:
    assert property ($rose(READY_BUSY_N_O) |-> busy_q >= PROG_CYC - 4 && busy_q <= ERASE_CYC + 16)
    else $error("busy span out of range");
  mode_exit_a:
    assert property (!HV_I [*8] |-> !PROG_MODE_O) else $error("mode kept without voltage");
  entry_quiet_a:
    assert property ($rose(PROG_MODE_O) |-> $past(HV_I, 4) && $past(quiet, 4))
    else $error("mode entered with selects active");
endmodule // ppp_port_props
bind ppp_port ppp_port_props #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) u_props (
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .HV_I(HV_I), .ACTION_SEL_BIT0_I(ACTION_SEL_BIT0_I),
  .ACTION_SEL_BIT1_I(ACTION_SEL_BIT1_I), .BYTE_SELECT_LO_BIT_I(BYTE_SELECT_LO_BIT_I),
  .PAGE_LATCH_STROBE_I(PAGE_LATCH_STROBE_I), .WR_N_I(WR_N_I), .OE_N_I(OE_N_I),
  .DATA_OE_O(DATA_OE_O), .READY_BUSY_N_O(READY_BUSY_N_O), .PROG_MODE_O(PROG_MODE_O));

//--- test/ppp_prog_model.sv
// Programmer model driving the parallel programming pins
`timescale 1ns/1ns
module ppp_prog_model (
  // Clock and device side
  input  wire logic       clk_i,
  input  wire logic [7:0] dev_data_i,
  input  wire logic       dev_oe_i,
  input  wire logic       ready_i,
  // Programming pins
  output logic            rst_pin_n_o,
  output logic            hv_o,
  output logic            ls_o,
  output logic [1:0]      xa_o,
  output logic [1:0]      bs_o,
  output logic            pl_o,
  output logic            wr_n_o,
  output logic            oe_n_o,
  output wire  [7:0]      bus_o
);
  logic [7:0] dq = 8'h00;
  assign bus_o = dev_oe_i ? dev_data_i : (oe_n_o ? dq : ~dq);
  initial {rst_pin_n_o, hv_o, ls_o, xa_o, bs_o, pl_o, wr_n_o, oe_n_o} = 10'h3;
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic ld(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
    xa_o = a;
    bs_o = b;
    dq = d;
    wt(4);
    ls_o = 1'b1;
    wt(14);
    ls_o = 1'b0;
    wt(14);
  endtask
  task automatic latch();
    bs_o[0] = 1'b1;
    wt(4);
    pl_o = 1'b1;
    wt(14);
    pl_o = 1'b0;
    wt(14);
  endtask
  task automatic write(input logic [1:0] b, output int bc);
    bs_o = b;
    bc = 0;
    wt(4);
    wr_n_o = 1'b0;
    wt(14);
    wr_n_o = 1'b1;
    while (!ready_i && bc < 600) begin
      wt(1);
      bc++;
    end
  endtask
  task automatic read(input logic [1:0] b, output logic [7:0] q);
    bs_o = b;
    oe_n_o = 1'b0;
    wt(14);
    q = bus_o;
    oe_n_o = 1'b1;
    wt(14);
  endtask
  task automatic enter(input logic bad);
    hv_o = 1'b0;
    rst_pin_n_o = 1'b0;
    {pl_o, xa_o, bs_o} = 5'h0;
    repeat (14) begin
      wt(14);
      ls_o = ~ls_o;
    end
    wt(6);
    hv_o = 1'b1;
    wt(1);
    xa_o[0] = bad;
    wt(2500);
    xa_o = 2'b11;
  endtask
endmodule // ppp_prog_model

//--- test/test_ppp_port.sv
// Self-checking bench for the parallel programming port
`timescale 1ns/1ns
module test_ppp_port;
  localparam [7:0] SIG0 = 8'h3c; // Arbitrary value
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  wire         rst_pin_n, hv, ls, pl, wr_n, oe_n, doe, rdy, mode;
  wire  [1:0]  xa, bs;
  wire  [7:0]  bus, dout;
  logic [7:0]  q, e, v;
  logic [9:0]  ad;
  logic [15:0] w, w0, w1;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          seed = 88;
  int          bc;
  always #10 clk = ~clk;
  ppp_port #(.SIG0(SIG0)) dut (
    .MCLK_I(clk), .RSTN_I(rstn), .RESET_PIN_N_I(rst_pin_n), .HV_I(hv),
    .LOAD_STROBE_CLOCK_I(ls), .ACTION_SEL_BIT0_I(xa[0]), .ACTION_SEL_BIT1_I(xa[1]),
    .BYTE_SELECT_LO_BIT_I(bs[0]), .BYTE_SELECT_HI_BIT_I(bs[1]), .PAGE_LATCH_STROBE_I(pl),
    .WR_N_I(wr_n), .OE_N_I(oe_n), .DATA_I(bus), .DATA_O(dout), .DATA_OE_O(doe),
    .READY_BUSY_N_O(rdy), .PROG_MODE_O(mode));
  ppp_prog_model prg (
    .clk_i(clk), .dev_data_i(dout), .dev_oe_i(doe), .ready_i(rdy), .rst_pin_n_o(rst_pin_n),
    .hv_o(hv), .ls_o(ls), .xa_o(xa), .bs_o(bs), .pl_o(pl), .wr_n_o(wr_n), .oe_n_o(oe_n),
    .bus_o(bus));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    prg.ld(2'b10, 2'b00, c);
  endtask
  task automatic wr(input logic [1:0] b);
    prg.write(b, bc);
    chk("busy", 16'h1, bc > 100 && bc < 450);
  endtask
  task automatic rdw(input logic [9:0] a, output logic [15:0] r);
    cmd(8'h02);
    prg.ld(2'b00, 2'b10, 8'h00);
    prg.ld(2'b00, 2'b01, {6'h0, a[9:8]});
    prg.ld(2'b00, 2'b00, a[7:0]);
    prg.read(2'b00, r[7:0]);
    prg.read(2'b01, r[15:8]);
  endtask
  task automatic erd(input logic [7:0] a);
    cmd(8'h03);
    prg.ld(2'b00, 2'b01, 8'h00);
    prg.ld(2'b00, 2'b00, a);
    prg.read(2'b00, q);
  endtask
  function automatic logic [15:0] fexp(input int i, input logic [7:0] fh, input logic [7:0] lk);
    logic [7:0] t [4];
    t = '{8'h62, lk, 8'hff, fh};
    return {8'h0, t[i]};
  endfunction
  task automatic fuses(input logic [7:0] fh, input logic [7:0] lk);
    cmd(8'h04);
    for (int i = 0; i < 4; i++) begin
      prg.read(i[1:0], q);
      chk("fuse", fexp(i, fh, lk), {8'h0, q});
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("idle", 16'h4, {rdy, mode, doe});
    prg.enter(1'b1);
    chk("aborted entry", 16'h0, mode);
    prg.enter(1'b0);
    chk("entry", 16'h1, mode);
    $display("test entry done");
    cmd(8'h80);
    wr(2'b00);
    ad = $random(seed);
    w0 = $random(seed);
    w1 = $random(seed);
    cmd(8'h10);
    for (int i = 0; i < 2; i++) begin
      prg.ld(2'b00, 2'b00, ad[7:0] ^ i[7:0]);
      prg.ld(2'b01, 2'b00, i ? w1[7:0] : w0[7:0]);
      prg.ld(2'b01, 2'b01, i ? w1[15:8] : w0[15:8]);
      prg.latch();
    end
    prg.ld(2'b00, 2'b01, {6'h0, ad[9:8]});
    wr(2'b00);
    cmd(8'h00);
    rdw(ad, w);
    chk("flash word", w0, w);
    rdw(ad ^ 10'h1, w);
    chk("flash word", w1, w);
    rdw(ad ^ 10'h40, w);
    chk("erased page", 16'hffff, w);
    $display("test flash done");
    e = $random(seed);
    v = $random(seed);
    cmd(8'h11);
    prg.ld(2'b00, 2'b01, 8'h00);
    prg.ld(2'b00, 2'b00, e);
    prg.ld(2'b01, 2'b00, v);
    prg.latch();
    wr(2'b00);
    erd(e);
    chk("eeprom", v, q);
    fuses(8'h99, 8'hff);
    cmd(8'h40);
    prg.ld(2'b01, 2'b00, 8'h91);
    wr(2'b01);
    cmd(8'h20);
    prg.ld(2'b01, 2'b00, 8'hfc);
    wr(2'b00);
    fuses(8'h91, 8'hfc);
    cmd(8'h80);
    wr(2'b00);
    fuses(8'h91, 8'hff);
    erd(e);
    chk("kept eeprom", v, q);
    cmd(8'h08);
    prg.ld(2'b00, 2'b00, 8'h00);
    prg.read(2'b00, q);
    chk("signature", SIG0, q);
    $display("test fuses done");
    prg.hv_o = 1'b0;
    repeat (8) @(negedge clk);
    chk("exit", 16'h0, mode);
    final_report();
  end
endmodule // test_ppp_port
